// File: src/gtw_defines.vh
/*
 * Constants for the two-wire slave port of the gauge: bus address,
 * address limits, state codes and the rate figures the sampler relies on.
 * Assumes it is included by bare name from the design files.
 */
`ifndef GTW_DEFINES_VH
`define GTW_DEFINES_VH

// Fixed 7-bit bus address; 6Ch/6Dh once the direction bit is appended
`define GTW_BUS_DEVICE_ADDRESS 7'h36
// Last byte address that a write may still reach
`define GTW_WR_LAST_ADDR 9'h04F
// Byte returned once a read runs past the top of the map
`define GTW_RD_FILL_BYTE 8'hFF
// Bits in a byte on the wire
`define GTW_BYTE_BITS 4'h8

// Rates: fastest serial clock, core clock, and the resulting core cycles
// in the shortest serial half period (must stay well above 3 sync stages)
`define GTW_SCL_MAX_KHZ 400
`define GTW_CORE_KHZ 125000
`define GTW_HALF_PERIOD_CYC (`GTW_CORE_KHZ / (2 * `GTW_SCL_MAX_KHZ))

// One-hot states
`define GTW_ST_IDLE 5'h01
`define GTW_ST_RX 5'h02
`define GTW_ST_ACK 5'h04
`define GTW_ST_TX 5'h08
`define GTW_ST_MACK 5'h10

// What the byte being received means
`define GTW_KIND_ADDR 2'h0
`define GTW_KIND_PTR 2'h1
`define GTW_KIND_DATA 2'h2

`endif

// File: src/gtw_pair_buf.v
/*
 * Small FIFO of flip-flops with valid/ready on both sides.
 * Assumes one clock, synchronous active-high reset; DEPTH a power of two.
 */
`timescale 1ns/1ns
module gtw_pair_buf #(
    parameter WIDTH = 24,
    parameter AW = 1
) (
    input wire core_clk_i,              // Core clock
    input wire srst_i,                  // Synchronous reset, active high
    input wire in_valid_i,              // Word offered
    output wire in_ready_o,             // Room for a word
    input wire [WIDTH-1:0] in_data_i,   // Word in
    output wire out_valid_o,            // Word available
    input wire out_ready_i,             // Sink takes word
    output wire [WIDTH-1:0] out_data_o  // Word out
);
    localparam DEPTH = 1 << AW;

    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0] wr_idx_q;
    reg [AW-1:0] rd_idx_q;
    reg [AW:0] count_q;
    wire push;
    wire pop;
    integer i;

    // Count never exceeds DEPTH, so its top bit alone marks a full buffer
    assign in_ready_o = !count_q[AW];
    assign out_valid_o = (count_q != {(AW+1){1'b0}});
    assign out_data_o = mem_q[rd_idx_q];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always @(posedge core_clk_i) begin
        if (srst_i) begin
            wr_idx_q <= {AW{1'b0}};
            rd_idx_q <= {AW{1'b0}};
            count_q <= {(AW+1){1'b0}};
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem_q[i] <= {WIDTH{1'b0}};
            end
        end else begin
            if (push) begin
                mem_q[wr_idx_q] <= in_data_i;
                wr_idx_q <= wr_idx_q + 1'b1;
            end
            if (pop) begin
                rd_idx_q <= rd_idx_q + 1'b1;
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule

// File: src/gtw_slave.v
/*
 * Slave-only two-wire port: recognises the fixed address, keeps the byte
 * pointer, assembles 16-bit register writes and serves read bytes.
 * Assumes the register bank answers rd_data_i combinationally for
 * rd_addr_o, and reg_writable_i for the register holding rd_addr_o.
 * SCL and SDA come from pins and are synchronised here.
 */
// Notes on behaviour
// - Slave only; answers address 0110110, i.e. 6Ch write and 6Dh read.
// - Any serial clock up to 400kHz works without configuration.
// - SDA is open drain when sending and an input when receiving.
// - One bit per SCL cycle; SDA stays stable while SCL is high.
// - An SDA change while SCL is high is START or STOP, never data.
// - Repeated START ends one transaction and opens the next.
// - Acknowledge holds SDA low over the ninth pulse; released means no-ack.
// - Bytes are eight bits, MSB first, acknowledge right after the LSB.
// - Register MSB lives at the even byte address, LSB at the odd.
// - Idle port waits for START plus own address, then acknowledges.
// - Direction bit 0 is a write, 1 is a read.
// - Every byte is acknowledged before the next one moves.
// - First written byte sets the pointer; pointer steps after each byte.
// - Write bytes past address 4Fh are discarded.
// - A register changes only when both its bytes arrive in one write.
// - Bytes written to read-only addresses are discarded.
// - Cut-short or unacknowledged bytes are never stored.
// - Read: pointer write, Repeated START, address with bit 1, device drives.
// - Master no-ack ends a read; device releases SDA and stops sending.
// - Reads past FFh return FFh.
`timescale 1ns/1ns
`include "gtw_defines.vh"
module gtw_slave #(
    parameter BUF_AW = 1
) (
    input wire core_clk_i,         // Core clock, 125 MHz
    input wire srst_i,             // Synchronous reset, active high
    input wire scl_i,              // Serial clock pin
    input wire sda_i,              // Serial data pin level
    output wire sda_o,             // Serial data drive value, always 0
    output reg sda_oe_o,           // High while pulling SDA low
    output wire [7:0] rd_addr_o,   // Byte address for read data
    input wire [7:0] rd_data_i,    // Byte at rd_addr_o
    input wire reg_writable_i,     // Register at rd_addr_o is writable
    output wire wr_valid_o,        // Register write offered
    input wire wr_ready_i,         // Bank takes the write
    output wire [7:0] wr_addr_o,   // Even byte address of the register
    output wire [15:0] wr_data_o,  // Register value, MSB byte high
    output wire busy_o             // Inside a transaction, from START on
);
    reg scl_m_q;
    reg scl_s_q;
    reg scl_d_q;
    reg sda_m_q;
    reg sda_s_q;
    reg sda_d_q;

    // No speed setting
    // Edges are found by sampling, so any SCL rate works while each phase spans several cycles
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            scl_d_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_d_q <= 1'b1;
        end else begin
            scl_m_q <= scl_i;
            scl_s_q <= scl_m_q;
            scl_d_q <= scl_s_q;
            sda_m_q <= sda_i;
            sda_s_q <= sda_m_q;
            sda_d_q <= sda_s_q;
        end
    end

    wire scl_rise = scl_s_q && !scl_d_q;
    wire scl_fall = !scl_s_q && scl_d_q;
    wire start_det = scl_s_q && scl_d_q && sda_d_q && !sda_s_q;
    wire stop_det = scl_s_q && scl_d_q && !sda_d_q && sda_s_q;

    reg [4:0] state_q;
    reg [1:0] kind_q;
    reg [3:0] bit_cnt_q;
    reg [7:0] shift_q;
    reg rw_q;
    reg ack_q;
    reg commit_q;
    reg mack_q;
    reg [8:0] ptr_q;
    reg [7:0] msb_q;
    reg msb_pend_q;
    reg [7:0] wr_addr_q;
    reg [7:0] wr_lsb_q;

    wire buf_in_ready;
    wire buf_push = commit_q && scl_fall && (state_q == `GTW_ST_ACK);
    wire [7:0] tx_byte = ptr_q[8] ? `GTW_RD_FILL_BYTE : rd_data_i;
    wire [7:0] rx_byte = {shift_q[6:0], sda_s_q};
    wire ptr_in_map = (ptr_q <= `GTW_WR_LAST_ADDR);
    wire [8:0] ptr_next = ptr_q[8] ? ptr_q : ptr_q + 9'h001;

    assign sda_o = 1'b0;
    assign rd_addr_o = ptr_q[7:0];
    assign busy_o = (state_q != `GTW_ST_IDLE);

    gtw_pair_buf #(
        .WIDTH(24),
        .AW(BUF_AW)
    ) u_buf (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .in_valid_i(buf_push),
        .in_ready_o(buf_in_ready),
        .in_data_i({wr_addr_q, msb_q, wr_lsb_q}),
        .out_valid_o(wr_valid_o),
        .out_ready_i(wr_ready_i),
        .out_data_o({wr_addr_o, wr_data_o})
    );

    always @(posedge core_clk_i) begin
        if (srst_i) begin
            state_q <= `GTW_ST_IDLE;
            kind_q <= `GTW_KIND_ADDR;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            rw_q <= 1'b0;
            ack_q <= 1'b0;
            commit_q <= 1'b0;
            mack_q <= 1'b0;
            ptr_q <= 9'h000;
            msb_q <= 8'h00;
            msb_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            wr_lsb_q <= 8'h00;
            sda_oe_o <= 1'b0;
        end else if (start_det) begin
            state_q <= `GTW_ST_RX;
            kind_q <= `GTW_KIND_ADDR;
            bit_cnt_q <= 4'h0;
            msb_pend_q <= 1'b0;
            commit_q <= 1'b0;
            sda_oe_o <= 1'b0;
        end else if (stop_det) begin
            state_q <= `GTW_ST_IDLE;
            msb_pend_q <= 1'b0;
            commit_q <= 1'b0;
            sda_oe_o <= 1'b0;
        end else begin
            case (state_q)
                `GTW_ST_IDLE: begin
                    sda_oe_o <= 1'b0;
                end
                `GTW_ST_RX: begin
                    if (scl_rise && bit_cnt_q != `GTW_BYTE_BITS) begin
                        shift_q <= rx_byte;
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                        if (bit_cnt_q == `GTW_BYTE_BITS - 4'h1) begin
                            commit_q <= 1'b0;
                            case (kind_q)
                                `GTW_KIND_ADDR: begin
                                    ack_q <= (rx_byte[7:1] == `GTW_BUS_DEVICE_ADDRESS);
                                    rw_q <= rx_byte[0];
                                end
                                `GTW_KIND_PTR: begin
                                    ack_q <= 1'b1;
                                    ptr_q <= {1'b0, rx_byte};
                                end
                                default: begin
                                    ptr_q <= ptr_next;
                                    ack_q <= 1'b1;
                                    if (!ptr_q[0]) begin
                                        msb_q <= rx_byte;
                                        msb_pend_q <= ptr_in_map;
                                    end else begin
                                        msb_pend_q <= 1'b0;
                                        wr_lsb_q <= rx_byte;
                                        wr_addr_q <= {ptr_q[7:1], 1'b0};
                                        if (msb_pend_q && ptr_in_map && reg_writable_i) begin
                                            // Full buffer: refuse rather than lose
                                            ack_q <= buf_in_ready;
                                            commit_q <= buf_in_ready;
                                        end
                                    end
                                end
                            endcase
                        end
                    end else if (scl_fall && bit_cnt_q == `GTW_BYTE_BITS) begin
                        state_q <= `GTW_ST_ACK;
                        sda_oe_o <= ack_q;
                    end
                end
                `GTW_ST_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_q <= 4'h0;
                        commit_q <= 1'b0;
                        if (!ack_q) begin
                            state_q <= `GTW_ST_IDLE;
                            sda_oe_o <= 1'b0;
                        end else if (kind_q == `GTW_KIND_ADDR && rw_q) begin
                            state_q <= `GTW_ST_TX;
                            shift_q <= {tx_byte[6:0], 1'b0};
                            sda_oe_o <= !tx_byte[7];
                            ptr_q <= ptr_next;
                        end else begin
                            state_q <= `GTW_ST_RX;
                            kind_q <= (kind_q == `GTW_KIND_ADDR) ? `GTW_KIND_PTR
                                                                 : `GTW_KIND_DATA;
                            sda_oe_o <= 1'b0;
                        end
                    end
                end
                `GTW_ST_TX: begin
                    if (scl_fall) begin
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                        if (bit_cnt_q == `GTW_BYTE_BITS - 4'h1) begin
                            state_q <= `GTW_ST_MACK;
                            sda_oe_o <= 1'b0;
                        end else begin
                            sda_oe_o <= !shift_q[7];
                            shift_q <= {shift_q[6:0], 1'b0};
                        end
                    end
                end
                `GTW_ST_MACK: begin
                    if (scl_rise) begin
                        mack_q <= !sda_s_q;
                    end else if (scl_fall) begin
                        bit_cnt_q <= 4'h0;
                        if (mack_q) begin
                            state_q <= `GTW_ST_TX;
                            shift_q <= {tx_byte[6:0], 1'b0};
                            sda_oe_o <= !tx_byte[7];
                            ptr_q <= ptr_next;
                        end else begin
                            state_q <= `GTW_ST_IDLE;
                            sda_oe_o <= 1'b0;
                        end
                    end
                end
                default: begin
                    state_q <= `GTW_ST_IDLE;
                    sda_oe_o <= 1'b0;
                end
            endcase
        end
    end
endmodule

// File: bench/gtw_slave_properties.sv
/* Concurrent checks on the pins of the two-wire slave port.
   Assumes one core clock domain and a pulled-up data wire. */
`timescale 1ns/1ns
module gtw_slave_checker (
    input wire core_clk_i,        // Core clock
    input wire srst_i,            // Sync reset
    input wire scl_i,             // Serial clock
    input wire sda_i,             // Data wire
    input wire sda_o,             // Drive value
    input wire sda_oe_o,          // Pull enable
    input wire [7:0] rd_addr_o,   // Pointer
    input wire [7:0] rd_data_i,   // Bank byte
    input wire reg_writable_i,    // Writable
    input wire wr_valid_o,        // Write offered
    input wire wr_ready_i,        // Write taken
    input wire [7:0] wr_addr_o,   // Write address
    input wire [15:0] wr_data_o,  // Write value
    input wire busy_o             // In transaction
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    a_drive_zero: assert property (sda_o == 1'b0)
        else $error("data drive value not low");
    a_drive_busy: assert property (sda_oe_o |-> busy_o)
        else $error("data pulled while idle");
    a_drive_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("data drive changed while clock high");
    a_start_seen: assert property ($rose(busy_o) |-> scl_i && !sda_i)
        else $error("busy rose without a start");
    a_stop_idle: assert property (scl_i && $rose(sda_i) |-> ##[1:8] !busy_o)
        else $error("stop did not return to idle");
    a_idle_ptr: assert property (!busy_o && $past(!busy_o) |-> $stable(rd_addr_o))
        else $error("pointer moved while idle");
    a_hold_stall: assert property (wr_valid_o && !wr_ready_i |=>
        wr_valid_o && $stable({wr_addr_o, wr_data_o}))
        else $error("stalled write lost or changed");
    a_even_reg: assert property (wr_valid_o |-> !wr_addr_o[0])
        else $error("odd register address written");
    a_map_limit: assert property (wr_valid_o |-> wr_addr_o <= 8'h4E)
        else $error("write beyond writable map");
    a_reset_quiet: assert property ($fell(srst_i) |->
        !busy_o && !wr_valid_o && !sda_oe_o)
        else $error("outputs active after reset");
    c_stall: cover property (wr_valid_o && !wr_ready_i);
    c_take: cover property (wr_valid_o && wr_ready_i);
    c_drive: cover property ($rose(sda_oe_o));
endmodule
bind gtw_slave gtw_slave_checker chk_u (.core_clk_i(core_clk_i), .srst_i(srst_i),
    .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .rd_addr_o(rd_addr_o), .rd_data_i(rd_data_i), .reg_writable_i(reg_writable_i),
    .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i), .wr_addr_o(wr_addr_o),
    .wr_data_o(wr_data_o), .busy_o(busy_o));

// File: bench/gtw_master_model.sv
/* Behavioural two-wire bus master with a 160 ns serial clock.
   Assumes an external pull-up: the wire is high unless someone pulls it. */
`timescale 1ns/1ns
module gtw_master_model (
    input wire sda_i,      // Data wire
    output reg scl_o,      // Serial clock
    output reg sda_oe_o    // High while pulling data low
);
    localparam Q = 40;
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    // falling data with clock high, also as repeat start
    task start;
        sda_oe_o = 1'b0;
        #Q scl_o = 1'b1;
        #Q sda_oe_o = 1'b1;
        #80 scl_o = 1'b0;
        #Q;
    endtask
    task stop;
        #Q sda_oe_o = 1'b1;
        #Q scl_o = 1'b1;
        #Q sda_oe_o = 1'b0;
        #Q;
    endtask
    // data changes only while the clock is low
    task clk_bit(input b, output s);
        #Q sda_oe_o = ~b;
        #Q scl_o = 1'b1;
        #Q s = sda_i;
        #Q scl_o = 1'b0;
    endtask
    // MSB first; n below 8 cuts the byte short
    task wbyte(input [7:0] b, input int n, output reg ak);
        int i;
        reg s;
        for (i = 7; i > 7 - n; i--)
            clk_bit(b[i], s);
        ak = 1'b0;
        if (n == 8) begin
            clk_bit(1'b1, s);
            ak = ~s;
        end
    endtask
    // acknowledge each byte, refuse the last
    task rbyte(input nak, output reg [7:0] d);
        int i;
        reg s;
        for (i = 7; i >= 0; i--)
            clk_bit(1'b1, d[i]);
        clk_bit(nak, s);
    endtask
endmodule

// File: bench/test_gtw_slave.sv
/* Self-checking bench for the two-wire slave port with a master model.
   Assumes the bank answers rd_data_i combinationally; 08h-09h read-only. */
`timescale 1ns/1ns
module test_gtw_slave;
    reg core_clk_i = 1'b0;
    reg srst_i = 1'b1;
    reg wr_ready_i = 1'b0;
    reg stall_q = 1'b0;
    reg [31:0] rng_q = 32'h000158A3;
    reg [31:0] bad = 32'h6EEC004C;
    reg [23:0] exp_q[$];
    reg [7:0] db[0:7];
    reg [7:0] d;
    reg [7:0] p;
    reg a;
    int error_cnt = 0;
    int n_compared = 0;
    int cyc = 0;
    int k;
    wire scl, m_oe, sda_o, sda_oe_o, wr_valid_o, busy_o;
    wire [7:0] rd_addr_o, wr_addr_o;
    wire [15:0] wr_data_o;
    // Pull-up: low whenever either party pulls
    wire sda = ~(m_oe | sda_oe_o);
    wire [7:0] rd_data_i = rd_addr_o ^ 8'h5A;
    wire reg_writable_i = (rd_addr_o[7:1] != 7'h04);
    gtw_slave dut_u (.core_clk_i(core_clk_i), .srst_i(srst_i), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_o(sda_oe_o), .rd_addr_o(rd_addr_o), .rd_data_i(rd_data_i),
        .reg_writable_i(reg_writable_i), .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i),
        .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .busy_o(busy_o));
    gtw_master_model mm_u (.sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));
    initial forever #4 core_clk_i = ~core_clk_i;
    function [31:0] xs(input [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function [7:0] bank(input [8:0] ad);
        return (ad > 9'h0FF) ? 8'hFF : (ad[7:0] ^ 8'h5A);
    endfunction
    task check(input [23:0] got, input [23:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task fill(input int n);
        int i;
        for (i = 0; i < n; i++) begin
            @(posedge core_clk_i);
            db[i] = rng_q[7:0];
        end
        #1;
    endtask
    task expect_wr(input [7:0] ad, input int i);
        exp_q.push_back({ad, db[i], db[i+1]});
    endtask
    task wr_seq(input [7:0] ptr, input int n, input int nak_at);
        int i;
        mm_u.start;
        mm_u.wbyte(8'h6C, 8, a);
        check(a, 1'b1);
        mm_u.wbyte(ptr, 8, a);
        check(a, 1'b1);
        for (i = 0; i < n; i++) begin
            mm_u.wbyte(db[i], 8, a);
            check(a, i != nak_at);
        end
    endtask
    task rd_seq(input [7:0] ptr, input int n);
        int i;
        wr_seq(ptr, 0, -1);
        mm_u.start;
        mm_u.wbyte(8'h6D, 8, a);
        check(a, 1'b1);
        for (i = 0; i < n; i++) begin
            mm_u.rbyte(i == n - 1, d);
            check(d, bank(9'({1'b0, ptr} + i)));
        end
        mm_u.stop;
    endtask
    // Random stalls on the bank side; stall_q forces a full buffer
    always @(posedge core_clk_i) begin
        rng_q <= xs(rng_q);
        wr_ready_i <= #1 !stall_q && (rng_q[1:0] != 2'b00);
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt++;
            report_and_stop;
        end
    end
    always @(posedge core_clk_i)
        if (!srst_i && wr_valid_o === 1'b1 && wr_ready_i === 1'b1)
            check({wr_addr_o, wr_data_o}, exp_q.size() ? exp_q.pop_front() : 24'hXXXXXX);
    initial begin
        repeat (4) @(posedge core_clk_i);
        #1 srst_i = 1'b0;
        repeat (5) @(posedge core_clk_i);
        fill(2);
        expect_wr(8'h0C, 0);
        wr_seq(8'h0C, 2, -1);
        fill(8);
        expect_wr(8'h4C, 0);
        expect_wr(8'h4E, 2);
        wr_seq(8'h4C, 8, -1);
        fill(4);
        expect_wr(8'h0A, 2);
        wr_seq(8'h08, 4, -1);
        fill(3);
        expect_wr(8'h0E, 1);
        wr_seq(8'h0D, 3, -1);
        mm_u.stop;
        for (k = 0; k < 4; k++) begin
            mm_u.start;
            mm_u.wbyte(bad[8*k +: 8], 8, a);
            check(a, 1'b0);
            mm_u.stop;
        end
        fill(2);
        wr_seq(8'h10, 1, -1);
        mm_u.wbyte(db[1], 4, a);
        mm_u.stop;
        wr_seq(8'h10, 1, -1);
        mm_u.wbyte(db[1], 3, a);
        expect_wr(8'h12, 0);
        wr_seq(8'h12, 2, -1);
        mm_u.stop;
        rd_seq(8'h0C, 3);
        rd_seq(8'hFE, 4);
        stall_q = 1'b1;
        fill(6);
        expect_wr(8'h20, 0);
        expect_wr(8'h22, 2);
        wr_seq(8'h20, 6, 5);
        mm_u.stop;
        stall_q = 1'b0;
        for (k = 0; k < 5; k++) begin
            fill(2);
            p = 8'h10 + {2'b00, rng_q[4:0], 1'b0};
            expect_wr(p, 0);
            wr_seq(p, 2, -1);
            mm_u.stop;
        end
        repeat (300) @(posedge core_clk_i);
        check(exp_q.size(), 24'h000000);
        report_and_stop;
    end
endmodule
